// file: verilog/fes_defines.svh
// Timing counts for the floating-point error signalling block.
// Assumes inclusion by bare name from design files.
`ifndef FES_DEFINES_SVH
`define FES_DEFINES_SVH

// Cycles an instruction spends executing after its interrupt window
`define FES_EXEC_CYCLES 8'h04
// Cycles the interrupt sampling window stays open
`define FES_WINDOW_CYCLES 8'h02
// Cycles of the brief error pulse at a non-waiting instruction
`define FES_PULSE_CYCLES 8'h01

`endif

// file: verilog/fes_pkg.sv
// Types shared by the floating-point error signalling block.
// Assumes nothing of its surroundings.
package fes_pkg;

	// Class of an issued instruction
	typedef enum logic [1:0] {
		FES_CLS_WAIT = 2'h0,
		FES_CLS_ARITH = 2'h1,
		FES_CLS_NOWAIT = 2'h2
	} fes_cls_t;

	// Category of a detected numeric error
	typedef enum logic [1:0] {
		FES_EXC_DEFERRED = 2'h0,
		FES_EXC_IMMEDIATE = 2'h1,
		FES_EXC_SIMD = 2'h2
	} fes_exc_t;

	// Sequencer states
	typedef enum logic [2:0] {
		FES_ST_IDLE = 3'h0,
		FES_ST_PULSE = 3'h1,
		FES_ST_WIN = 3'h2,
		FES_ST_EXEC = 3'h3,
		FES_ST_FROZEN = 3'h4,
		FES_ST_SERVICE = 3'h5
	} fes_state_t;

endpackage

// file: verilog/fes_if.sv
// Carrier between the sequencer and its interrupt window timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface fes_win_if;
	logic window_req;
	logic window_done;
	logic maskable_interrupt_in_seen;

	modport ctl (output window_req, input window_done, input maskable_interrupt_in_seen);
	modport win (input window_req, output window_done, output maskable_interrupt_in_seen);
endinterface

// file: verilog/fes_window.sv
// Interrupt sampling window timer.
// Assumes window_req stays high for as long as the sequencer sits in its window state.
`timescale 1ns/1ns
`include "fes_defines.svh"
module fes_window #(
	parameter logic [7:0] WINDOW_CYCLES = `FES_WINDOW_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Interrupt pin and enable flag
	input wire logic maskable_interrupt_in,
	input wire logic interrupt_enable_flag,
	// Sequencer side
	fes_win_if.win wif
);

	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic open;

	////////////////////////////////////////////////////////////////////////////////
	// Window open while the count has not run out
	assign open = wif.window_req && (cnt != WINDOW_CYCLES);
	// Interrupt sampled only with the flag set and the window open
	assign wif.maskable_interrupt_in_seen = open && maskable_interrupt_in && interrupt_enable_flag;
	assign wif.window_done = wif.window_req && (cnt == WINDOW_CYCLES - 8'h01);

	// Next count
	always_comb begin
		if (!wif.window_req) begin
			next_cnt = 8'h00;
		end else if (open) begin
			next_cnt = cnt + 8'h01;
		end else begin
			next_cnt = cnt;
		end
	end

	// Count register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt <= 8'h00;
		end else begin
			cnt <= next_cnt;
		end
	end

endmodule // fes_window

// file: verilog/fes_top.sv
// Compatibility-mode error signalling for a floating-point unit.
// Assumes all inputs synchronous to sys_clk; the external latch, port-access
// flip-flops and interrupt controller sit outside and drive the interrupt pin.
`timescale 1ns/1ns
`include "fes_defines.svh"
module fes_top #(
	parameter logic [7:0] EXEC_CYCLES = `FES_EXEC_CYCLES,
	parameter logic [7:0] WINDOW_CYCLES = `FES_WINDOW_CYCLES,
	parameter logic [7:0] PULSE_CYCLES = `FES_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Instruction issue
	input wire logic instr_valid,
	input wire fes_pkg::fes_cls_t instr_class,
	output logic instr_ready,
	output logic instr_retire,
	// Error detection and clearing
	input wire logic exc_valid,
	input wire logic exc_unmasked,
	input wire fes_pkg::fes_exc_t exc_kind,
	input wire logic exc_clear,
	// Mode and flags
	input wire logic native_error_enable,
	input wire logic later_generation,
	input wire logic interrupt_enable_flag,
	// Interrupt handling
	input wire logic handler_return,
	output logic interrupt_ack,
	output logic frozen,
	// Pins
	input wire logic maskable_interrupt_in,
	input wire logic ignore_numeric_error_in_n,
	output logic fpu_error_out_n
);

	fes_pkg::fes_state_t state;
	fes_pkg::fes_state_t next_state;
	fes_pkg::fes_state_t resume;
	fes_pkg::fes_state_t next_resume;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic pending;
	logic next_pending;
	logic reported;
	logic next_reported;
	logic shown;
	logic next_shown;
	logic next_instr_ready;
	logic next_instr_retire;
	logic next_interrupt_ack;
	logic next_frozen;
	logic next_fpu_error_out_n;
	logic compat;
	logic ignore;
	logic take_irq;
	logic accept;
	logic exc_hit;
	logic exc_now;
	logic still_pending;

	// Carrier to the window timer; the sequencer owns the request line,
	// the timer owns the done and sampled-interrupt lines.
	fes_win_if wif ();

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt window timer
	fes_window #(
		.WINDOW_CYCLES(WINDOW_CYCLES)
	) u_window (
		.sys_clk(sys_clk),
		.reset(reset),
		.maskable_interrupt_in(maskable_interrupt_in),
		.interrupt_enable_flag(interrupt_enable_flag),
		.wif(wif)
	);

	assign wif.window_req = (state == fes_pkg::FES_ST_WIN);

	////////////////////////////////////////////////////////////////////////////////
	// Decoded conditions
	assign compat = !native_error_enable;
	assign ignore = !ignore_numeric_error_in_n;
	assign take_irq = maskable_interrupt_in && interrupt_enable_flag;
	assign accept = instr_valid && instr_ready;
	// Packed-SIMD errors never count as pending
	assign exc_hit = exc_valid && exc_unmasked && (exc_kind != fes_pkg::FES_EXC_SIMD);
	// Immediate report at detection: immediate category or later generation
	assign exc_now = exc_hit && (later_generation || exc_kind == fes_pkg::FES_EXC_IMMEDIATE);
	assign still_pending = pending && !exc_clear;

	////////////////////////////////////////////////////////////////////////////////
	// Error bookkeeping: a new error wins over a clear in the same cycle
	// pending marks an unmasked error not yet cleared by the handler.
	// reported marks that the pin has been told about it as a level;
	// a deferred error from an earlier generation only becomes reported when a waiting instruction
	// is taken, so a non-waiting instruction can still pulse before that.
	// Losing a same-cycle error to a clear would hide it from the handler,
	// hence the set is applied last.
	always_comb begin
		next_pending = pending;
		next_reported = reported;
		if (exc_clear) begin
			next_pending = 1'b0;
			next_reported = 1'b0;
		end
		if (accept && pending && instr_class != fes_pkg::FES_CLS_NOWAIT) begin
			next_reported = !exc_clear;
		end
		if (exc_hit) begin
			next_pending = 1'b1;
		end
		if (exc_now) begin
			next_reported = 1'b1;
		end
	end

	// Error level: raised only without ignore, held while the error stays pending
	// Once low, the level stays low under ignore so the external ignore flop,
	// which is cleared by the high pin, keeps its state inside the handler.
	always_comb begin
		next_shown = compat && next_pending && next_reported && (shown || !ignore);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	// One instruction at a time: ready is only high in the idle state.
	// Interrupts are taken in three places: the window, the boundary at the
	// end of execution (or while idle), and while frozen, so a late request
	// is never lost. Service entered from the window goes on to execution, otherwise back to idle or frozen;
	// the window is not reopened after a serviced interrupt.
	// A later-generation non-waiting instruction bypasses the window so it
	// cannot pick up the request raised by an earlier error.
	always_comb begin
		next_state = state;
		next_resume = resume;
		next_cnt = cnt;
		next_instr_retire = 1'b0;
		next_interrupt_ack = 1'b0;
		unique case (state)
			fes_pkg::FES_ST_IDLE: begin
				next_cnt = 8'h00;
				if (accept) begin
					if (compat && !ignore && still_pending &&
						instr_class != fes_pkg::FES_CLS_NOWAIT) begin
						next_state = fes_pkg::FES_ST_FROZEN;
					end else if (compat && !ignore && still_pending && !reported &&
						instr_class == fes_pkg::FES_CLS_NOWAIT) begin
						next_state = fes_pkg::FES_ST_PULSE;
					end else if (later_generation && instr_class == fes_pkg::FES_CLS_NOWAIT) begin
						next_state = fes_pkg::FES_ST_EXEC;
					end else begin
						next_state = fes_pkg::FES_ST_WIN;
					end
				end else if (take_irq) begin
					next_state = fes_pkg::FES_ST_SERVICE;
					next_resume = fes_pkg::FES_ST_IDLE;
					next_interrupt_ack = 1'b1;
				end
			end
			fes_pkg::FES_ST_PULSE: begin
				// Pulse ends and the instruction carries on, no freeze
				if (cnt == PULSE_CYCLES - 8'h01) begin
					next_cnt = 8'h00;
					next_state = later_generation ? fes_pkg::FES_ST_EXEC
						: fes_pkg::FES_ST_WIN;
				end else begin
					next_cnt = cnt + 8'h01;
				end
			end
			fes_pkg::FES_ST_WIN: begin
				// Interrupt inside the window is serviced before execution resumes
				if (wif.maskable_interrupt_in_seen) begin
					next_state = fes_pkg::FES_ST_SERVICE;
					next_resume = fes_pkg::FES_ST_EXEC;
					next_interrupt_ack = 1'b1;
				end else if (wif.window_done) begin
					next_state = fes_pkg::FES_ST_EXEC;
				end
			end
			fes_pkg::FES_ST_EXEC: begin
				if (cnt == EXEC_CYCLES - 8'h01) begin
					next_cnt = 8'h00;
					next_instr_retire = 1'b1;
					// Late interrupt taken at the instruction boundary
					if (take_irq) begin
						next_state = fes_pkg::FES_ST_SERVICE;
						next_resume = fes_pkg::FES_ST_IDLE;
						next_interrupt_ack = 1'b1;
					end else begin
						next_state = fes_pkg::FES_ST_IDLE;
					end
				end else begin
					next_cnt = cnt + 8'h01;
				end
			end
			fes_pkg::FES_ST_FROZEN: begin
				// Thaw once cleared, ignored, or native mode chosen
				if (!compat || !still_pending || ignore) begin
					next_state = fes_pkg::FES_ST_WIN;
				end else if (take_irq) begin
					next_state = fes_pkg::FES_ST_SERVICE;
					next_resume = fes_pkg::FES_ST_FROZEN;
					next_interrupt_ack = 1'b1;
				end
			end
			fes_pkg::FES_ST_SERVICE: begin
				if (handler_return) begin
					next_state = resume;
				end
			end
			default: begin
				next_state = fes_pkg::FES_ST_IDLE;
			end
		endcase
		next_instr_ready = (next_state == fes_pkg::FES_ST_IDLE);
		next_frozen = (next_state == fes_pkg::FES_ST_FROZEN);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error pin: level from the held error, or the brief non-waiting pulse
	always_comb begin
		// Pulse only when no level is showing and the error is still pending
		next_fpu_error_out_n = !(next_shown ||
			(next_state == fes_pkg::FES_ST_PULSE && compat && next_pending));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	// Every output is registered straight from its next value, so the pins
	// change one cycle after the condition that moves them; the pin rests
	// high and ready rests low while reset is held.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= fes_pkg::FES_ST_IDLE;
			resume <= fes_pkg::FES_ST_IDLE;
			cnt <= 8'h00;
			pending <= 1'b0;
			reported <= 1'b0;
			shown <= 1'b0;
			instr_ready <= 1'b0;
			instr_retire <= 1'b0;
			interrupt_ack <= 1'b0;
			frozen <= 1'b0;
			fpu_error_out_n <= 1'b1;
		end else begin
			state <= next_state;
			resume <= next_resume;
			cnt <= next_cnt;
			pending <= next_pending;
			reported <= next_reported;
			shown <= next_shown;
			instr_ready <= next_instr_ready;
			instr_retire <= next_instr_retire;
			interrupt_ack <= next_interrupt_ack;
			frozen <= next_frozen;
			fpu_error_out_n <= next_fpu_error_out_n;
		end
	end

endmodule // fes_top

// file: dv/fes_latch_model.sv
// Model of the external error latch and the ignore flip-flop.
// Assumes port_access is a one-cycle pulse from the handler.
`timescale 1ns/1ns
module fes_latch_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Processor pins
	input wire logic fpu_error_out_n,
	output logic fpu_request_latch,
	output logic ignore_numeric_error_in_n,
	// Handler port access
	input wire logic port_access
);
	logic pin_last;
	logic ignore_ff;
	// Request latch catches any falling pin, even a one-cycle pulse
	always_ff @(posedge sys_clk) begin
		pin_last <= fpu_error_out_n;
		if (reset || port_access) begin
			fpu_request_latch <= 1'h0;
		end else if (pin_last && !fpu_error_out_n) begin
			fpu_request_latch <= 1'h1;
		end
	end
	// Ignore flop held clear whenever the pin is high
	always_ff @(posedge sys_clk or posedge fpu_error_out_n) begin
		if (fpu_error_out_n || reset) begin
			ignore_ff <= 1'h0;
		end else if (port_access) begin
			ignore_ff <= 1'h1;
		end
	end
	assign ignore_numeric_error_in_n = !ignore_ff;
endmodule // fes_latch_model

// file: dv/fes_monitor.sv
// Checker of error pin, freeze and interrupt acceptance.
// Assumes binding to fes_top; sees its ports only.
`timescale 1ns/1ns
module fes_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Watched ports
	input wire logic instr_valid,
	input wire fes_pkg::fes_cls_t instr_class,
	input wire logic instr_ready,
	input wire logic exc_valid,
	input wire logic exc_unmasked,
	input wire fes_pkg::fes_exc_t exc_kind,
	input wire logic exc_clear,
	input wire logic native_error_enable,
	input wire logic later_generation,
	input wire logic interrupt_enable_flag,
	input wire logic interrupt_ack,
	input wire logic frozen,
	input wire logic maskable_interrupt_in,
	input wire logic ignore_numeric_error_in_n,
	input wire logic fpu_error_out_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire logic take = instr_valid && instr_ready;
	wire logic nowait = instr_class == fes_pkg::FES_CLS_NOWAIT;
	wire logic ign_n = ignore_numeric_error_in_n;
	////////////////////////////////////////////////////////////////
	// Pin relations
	property p_native;
		native_error_enable && $past(native_error_enable) |-> fpu_error_out_n;
	endproperty
	a_native: assert property (p_native) else $error("pin low in native mode");
	property p_now;
		exc_valid && exc_unmasked && !native_error_enable && ign_n &&
		(exc_kind == fes_pkg::FES_EXC_IMMEDIATE || (later_generation &&
		exc_kind == fes_pkg::FES_EXC_DEFERRED)) |=> native_error_enable || !fpu_error_out_n;
	endproperty
	a_now: assert property (p_now) else $error("error not reported at once");
	property p_simd;
		exc_valid && exc_kind == fes_pkg::FES_EXC_SIMD && fpu_error_out_n && !instr_valid &&
		$stable(ign_n) |=> fpu_error_out_n;
	endproperty
	a_simd: assert property (p_simd) else $error("packed error drove pin");
	property p_held;
		take && nowait && !fpu_error_out_n && !exc_clear && !native_error_enable
		|=> !fpu_error_out_n;
	endproperty
	a_held: assert property (p_held) else $error("held pin released by pulse");
	property p_later;
		take && nowait && later_generation && fpu_error_out_n && !exc_valid && ign_n &&
		$past(ign_n) |=> fpu_error_out_n;
	endproperty
	a_later: assert property (p_later) else $error("later no-wait pulsed");
	////////////////////////////////////////////////////////////////
	// Freeze and interrupt relations
	property p_freeze;
		take && !nowait && !fpu_error_out_n && ign_n && !native_error_enable && !exc_clear
		|=> frozen;
	endproperty
	a_freeze: assert property (p_freeze) else $error("no freeze on pending");
	property p_release;
		frozen && !ign_n |-> ##[1:2] !frozen;
	endproperty
	a_release: assert property (p_release) else $error("freeze held with ignore");
	property p_ack;
		interrupt_ack |-> $past(interrupt_enable_flag && maskable_interrupt_in);
	endproperty
	a_ack: assert property (p_ack) else $error("ack without enabled request");
	c_pulse: cover property (take && nowait && fpu_error_out_n);
	c_ack: cover property (interrupt_ack);
	c_release: cover property (frozen && !ign_n);
endmodule // fes_monitor
bind fes_top fes_monitor u_fes_monitor (.sys_clk, .reset, .instr_valid, .instr_class,
	.instr_ready, .exc_valid, .exc_unmasked, .exc_kind, .exc_clear, .native_error_enable,
	.later_generation, .interrupt_enable_flag, .interrupt_ack, .frozen,
	.maskable_interrupt_in, .ignore_numeric_error_in_n, .fpu_error_out_n);

// file: dv/tb_top.sv
// Self-checking bench for the error signalling block and its latch.
// Assumes the latch model drives the interrupt and ignore pins.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic instr_valid = 1'h0;
	fes_pkg::fes_cls_t instr_class = fes_pkg::FES_CLS_WAIT;
	logic exc_valid = 1'h0;
	logic exc_unmasked = 1'h1;
	fes_pkg::fes_exc_t exc_kind = fes_pkg::FES_EXC_DEFERRED;
	logic exc_clear = 1'h0;
	logic native_error_enable = 1'h0;
	logic later_generation = 1'h0;
	logic interrupt_enable_flag = 1'h0;
	logic handler_return = 1'h0;
	logic port_access = 1'h0;
	logic instr_ready, instr_retire, interrupt_ack, frozen;
	logic maskable_interrupt_in, ignore_numeric_error_in_n, fpu_error_out_n;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	fes_top #(.WINDOW_CYCLES(8'h04)) u_fes_top (.sys_clk, .reset, .instr_valid, .instr_class,
		.instr_ready, .instr_retire, .exc_valid, .exc_unmasked, .exc_kind, .exc_clear,
		.native_error_enable, .later_generation, .interrupt_enable_flag, .handler_return,
		.interrupt_ack, .frozen, .maskable_interrupt_in, .ignore_numeric_error_in_n,
		.fpu_error_out_n);
	fes_latch_model u_fes_latch_model (.sys_clk, .reset, .fpu_error_out_n,
		.fpu_request_latch(maskable_interrupt_in), .ignore_numeric_error_in_n, .port_access);
	////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	// Drivers: error pulse, instruction offer, handler pulses, waits
	task automatic exc(input fes_pkg::fes_exc_t k);
		@(posedge sys_clk);
		exc_valid <= 1'h1;
		exc_kind <= k;
		@(posedge sys_clk);
		exc_valid <= 1'h0;
		#1;
	endtask
	task automatic issue(input fes_pkg::fes_cls_t c);
		@(posedge sys_clk);
		instr_valid <= 1'h1;
		instr_class <= c;
		for (int n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (instr_ready === 1'h1) break;
		end
		instr_valid <= 1'h0;
		#1;
	endtask
	task automatic pulse(input int which);
		@(posedge sys_clk);
		exc_clear <= which == 0;
		port_access <= which == 1;
		handler_return <= which == 2;
		@(posedge sys_clk);
		{exc_clear, port_access, handler_return} <= 3'h0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic wait_sig(input int which);
		for (int n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			#1;
			if ((which == 0 ? instr_retire : interrupt_ack) === 1'h1) break;
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_nowait_pulse();
		exc(fes_pkg::FES_EXC_DEFERRED);
		`CHK(fpu_error_out_n, 1'h1)
		issue(fes_pkg::FES_CLS_NOWAIT);
		`CHK(fpu_error_out_n, 1'h0)
		@(posedge sys_clk);
		#1;
		`CHK(fpu_error_out_n, 1'h1)
		`CHK(maskable_interrupt_in, 1'h1)
		wait_sig(0);
		`CHK(instr_retire, 1'h1)
		`CHK(frozen, 1'h0)
		`CHK(instr_ready, 1'h1)
		`CHK(interrupt_ack, 1'h0)
		interrupt_enable_flag <= 1'h1;
		wait_sig(1);
		`CHK(interrupt_ack, 1'h1)
		interrupt_enable_flag <= 1'h0;
		pulse(1);
		`CHK(maskable_interrupt_in, 1'h0)
		`CHK(ignore_numeric_error_in_n, 1'h1)
		pulse(0);
		pulse(2);
		`CHK(instr_ready, 1'h1)
		$display("test nowait_pulse done");
	endtask
	task automatic t_freeze();
		exc(fes_pkg::FES_EXC_IMMEDIATE);
		issue(fes_pkg::FES_CLS_ARITH);
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(frozen, 1'h1)
		pulse(1);
		`CHK(ignore_numeric_error_in_n, 1'h0)
		`CHK(frozen, 1'h0)
		pulse(0);
		`CHK(fpu_error_out_n, 1'h1)
		`CHK(ignore_numeric_error_in_n, 1'h1)
		wait_sig(0);
		`CHK(instr_retire, 1'h1)
		$display("test freeze done");
	endtask
	task automatic t_window();
		interrupt_enable_flag <= 1'h1;
		exc(fes_pkg::FES_EXC_DEFERRED);
		issue(fes_pkg::FES_CLS_NOWAIT);
		wait_sig(1);
		`CHK(interrupt_ack, 1'h1)
		pulse(1);
		pulse(0);
		pulse(2);
		wait_sig(0);
		`CHK(instr_retire, 1'h1)
		issue(fes_pkg::FES_CLS_NOWAIT);
		`CHK(fpu_error_out_n, 1'h1)
		wait_sig(0);
		interrupt_enable_flag <= 1'h0;
		$display("test window done");
	endtask
	task automatic t_modes();
		native_error_enable <= 1'h1;
		exc(fes_pkg::FES_EXC_IMMEDIATE);
		issue(fes_pkg::FES_CLS_ARITH);
		`CHK(fpu_error_out_n, 1'h1)
		wait_sig(0);
		`CHK(instr_retire, 1'h1)
		pulse(0);
		native_error_enable <= 1'h0;
		exc(fes_pkg::FES_EXC_SIMD);
		`CHK(fpu_error_out_n, 1'h1)
		later_generation <= 1'h1;
		exc(fes_pkg::FES_EXC_DEFERRED);
		`CHK(fpu_error_out_n, 1'h0)
		issue(fes_pkg::FES_CLS_NOWAIT);
		`CHK(fpu_error_out_n, 1'h0)
		wait_sig(0);
		pulse(0);
		later_generation <= 1'h0;
		$display("test modes done");
	endtask
	////////////////////////////////////////////////////////////////
	// Verdict and main sequence
	task automatic close_out();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'h0;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK(maskable_interrupt_in, 1'h0)
		`CHK(ignore_numeric_error_in_n, 1'h1)
		t_nowait_pulse();
		t_freeze();
		t_window();
		t_modes();
		close_out();
	end
endmodule // tb_top
